/* hw/csb_status_bank.sv */
// Operation
// (RULE1) Values stored binary unless BCD defined
// (RULE2) Software writes only with fixed purposes
// (RULE3) Store lowest module number with blown fuse
// (RULE4) Supply drop while running adds one
// (RULE5) Diagnosis error number stored in binary
// (RULE6) Word one: BCD year, BCD month
// (RULE7) Word two: BCD day, BCD hour
// (RULE8) Word three: BCD minute, BCD second
// (RULE9) Timestamps change only with an error
// (RULE10) Class code tells unit or parameter
// (RULE11) Processors one to four coded 1-4
// (RULE12) State field: 0 running, 2 stopped
// (RULE13) Cause 0 switch, 4 error, earliest kept
// (RULE14) State word refreshed each main pass
// (RULE15) Latest main cycle in milliseconds
// (RULE16) Longest main cycle since reset kept
// (RULE17) Clock word holds BCD year, month
// (RULE18) Clock word loads on request or write
// (RULE19) Error words all update together
// (RULE20) Counters and measures reset to zero
`timescale 1ns/10ps
`default_nettype none

module csb_status_bank #(
  parameter int N_MOD     = csb_pkg::N_MOD,
  parameter int MS_CYCLES = csb_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rstn_i,
  // Register port
  input  wire csb_pkg::csb_bus_req_t bus_i,
  output logic [15:0]               rd_data_o,
  // System events
  input  wire logic [N_MOD-1:0]     fuse_blown_i,
  input  wire logic                 supply_drop_i,
  input  wire csb_pkg::csb_err_t    err_i,
  input  wire csb_pkg::csb_time_t   rtc_i,
  input  wire logic                 run_switch_i,
  input  wire logic                 main_pass_i,
  input  wire logic                 clk_req_i,
  // Status
  output logic                      running_o
);

  logic [15:0] fuse_num;
  logic [15:0] drop_cnt;
  logic [15:0] err_num;
  logic [15:0] err_ym;
  logic [15:0] err_dh;
  logic [15:0] err_msec;
  logic [15:0] err_class;
  logic [15:0] err_info;
  logic [15:0] run_state;
  logic [15:0] cyc_time;
  logic [15:0] cyc_max;
  logic [15:0] clk_ym;
  logic        err_stop;
  logic [3:0]  live_cause;
  logic [31:0] ms_div;
  logic        ms_tick;
  logic [15:0] cyc_cnt;
  logic [15:0] next_fuse;
  logic [15:0] next_info;
  logic        live_run;

  ////////////////////////////////////////////////////////////////////////
  // Fuse scan

  // Scan from the top so the lowest set index wins
  always_comb begin
    next_fuse = fuse_num;
    for (int i = N_MOD - 1; i >= 0; i--) begin
      if (fuse_blown_i[i]) begin
        next_fuse = 16'(i); // RULE3
      end
    end
  end

  // No blown module leaves the last number in place
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fuse_num <= csb_pkg::RST_VAL;
    end else begin
      fuse_num <= next_fuse; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply drop counter

  // Saturates rather than wrapping so a flood never reads as few
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drop_cnt <= csb_pkg::RST_VAL; // RULE20
    end else if (supply_drop_i && live_run && drop_cnt != 16'hffff) begin
      drop_cnt <= drop_cnt + 16'h0001; // RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic error capture

  always_comb begin
    if (err_i.is_cpu) begin
      next_info = {14'h0000, err_i.cpu_idx} + 16'h0001; // RULE11
    end else begin
      next_info = err_i.number;
    end
  end

  // One enable for all six words keeps a report coherent
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_num   <= csb_pkg::RST_VAL;
      err_ym    <= csb_pkg::RST_VAL;
      err_dh    <= csb_pkg::RST_VAL;
      err_msec  <= csb_pkg::RST_VAL;
      err_class <= csb_pkg::RST_VAL;
      err_info  <= csb_pkg::RST_VAL;
    end else if (err_i.valid) begin // RULE9 RULE19
      err_num   <= err_i.code; // RULE5
      err_ym    <= {rtc_i.year, rtc_i.month}; // RULE6
      err_dh    <= {rtc_i.day, rtc_i.hour}; // RULE7
      err_msec  <= {rtc_i.minute, rtc_i.second}; // RULE8
      err_class <= err_i.is_param ? csb_pkg::CLASS_PARAM
                                  : csb_pkg::CLASS_UNIT; // RULE10
      err_info  <= next_info;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Run state

  // Error stop holds until reset, as a stop error needs a restart
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      err_stop <= 1'b0;
    end else if (err_i.valid && err_i.stop) begin
      err_stop <= 1'b1;
    end
  end

  assign live_run = run_switch_i && !err_stop;
  assign running_o = live_run;

  // Cause latched on the first stop only
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      live_cause <= csb_pkg::CAUSE_SWITCH;
    end else if (live_run) begin
      if (err_i.valid && err_i.stop) begin
        live_cause <= csb_pkg::CAUSE_ERROR; // RULE13
      end else begin
        live_cause <= csb_pkg::CAUSE_SWITCH; // RULE13
      end
    end
  end

  // Sampled on the pass, so the word lags the live state
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run_state <= csb_pkg::RST_VAL;
    end else if (main_pass_i) begin // RULE14
      run_state <= 16'h0000;
      run_state[csb_pkg::STATE_LSB +: 4] <= live_run ? csb_pkg::STATE_RUN
                                                     : csb_pkg::STATE_STOP; // RULE12
      run_state[csb_pkg::CAUSE_LSB +: 4] <= live_run ? csb_pkg::CAUSE_SWITCH
                                                     : live_cause;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Main cycle timing

  assign ms_tick = (ms_div == 32'(MS_CYCLES - 1));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ms_div <= 32'h00000000;
    end else if (main_pass_i || ms_tick) begin
      ms_div <= 32'h00000000;
    end else begin
      ms_div <= ms_div + 32'h00000001;
    end
  end

  // Counts whole ms since the last pass; the timebase restarts per pass
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_cnt <= csb_pkg::RST_VAL;
    end else if (main_pass_i) begin
      cyc_cnt <= 16'h0000;
    end else if (ms_tick && cyc_cnt != csb_pkg::CYC_SAT) begin
      cyc_cnt <= cyc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_time <= csb_pkg::RST_VAL;
      cyc_max  <= csb_pkg::RST_VAL; // RULE20
    end else if (main_pass_i) begin
      cyc_time <= cyc_cnt; // RULE15
      if (cyc_cnt > cyc_max) begin
        cyc_max <= cyc_cnt; // RULE16
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock data word

  // A same-cycle request beats the software write
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_ym <= csb_pkg::RST_VAL;
    end else if (clk_req_i) begin
      clk_ym <= {rtc_i.year, rtc_i.month}; // RULE17 RULE18
    end else if (bus_i.wr && bus_i.addr == csb_pkg::IDX_CLK_YM) begin
      clk_ym <= bus_i.wdata; // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  // Writes to status words are dropped; only the clock word is writable
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= 16'h0000;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        csb_pkg::IDX_FUSE:      rd_data_o <= fuse_num;
        csb_pkg::IDX_DROP_CNT:  rd_data_o <= drop_cnt;
        csb_pkg::IDX_ERR_NUM:   rd_data_o <= err_num;
        csb_pkg::IDX_ERR_YM:    rd_data_o <= err_ym;
        csb_pkg::IDX_ERR_DH:    rd_data_o <= err_dh;
        csb_pkg::IDX_ERR_MS:    rd_data_o <= err_msec;
        csb_pkg::IDX_ERR_CLASS: rd_data_o <= err_class;
        csb_pkg::IDX_ERR_INFO:  rd_data_o <= err_info;
        csb_pkg::IDX_RUN_STATE: rd_data_o <= run_state;
        csb_pkg::IDX_CYC_TIME:  rd_data_o <= cyc_time;
        csb_pkg::IDX_CYC_MAX:   rd_data_o <= cyc_max;
        csb_pkg::IDX_CLK_YM:    rd_data_o <= clk_ym;
        default:                rd_data_o <= 16'h0000;
      endcase
    end else begin
      rd_data_o <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_fuse_lowest: assert property ( // RULE3
    fuse_blown_i[0] |=> fuse_num == 16'h0000)
    else $error("fuse number not lowest");

  chk_drop_inc: assert property ( // RULE4
    supply_drop_i && live_run && drop_cnt != 16'hffff
      |=> drop_cnt == $past(drop_cnt) + 16'h0001)
    else $error("supply drop count not incremented");

  chk_drop_hold: assert property ( // RULE4
    !(supply_drop_i && live_run) |=> $stable(drop_cnt))
    else $error("supply drop count moved without event");

  chk_err_capture: assert property ( // RULE19
    err_i.valid |=> err_num == $past(err_i.code)
      && err_ym == $past({rtc_i.year, rtc_i.month})
      && err_msec == $past({rtc_i.minute, rtc_i.second}))
    else $error("error words not captured together");

  chk_stamp_hold: assert property ( // RULE9
    !err_i.valid |=> $stable(err_dh) && $stable(err_num))
    else $error("timestamp changed without error");

  chk_cpu_code: assert property ( // RULE11
    err_i.valid && err_i.is_cpu
      |=> err_info >= 16'h0001 && err_info <= 16'h0004)
    else $error("processor number out of range");

  chk_state_code: assert property ( // RULE12
    main_pass_i && !live_run
      |=> run_state[3:0] == csb_pkg::STATE_STOP)
    else $error("stopped state not coded 2");

  chk_cause_keep: assert property ( // RULE13
    !live_run ##1 !live_run |-> $stable(live_cause))
    else $error("stop cause overwritten");

  chk_max_cover: assert property ( // RULE16
    main_pass_i ##1 1'b1 |-> cyc_max >= cyc_time)
    else $error("maximum below latest cycle");

  chk_clock_req: assert property ( // RULE18
    clk_req_i |=> clk_ym == $past({rtc_i.year, rtc_i.month}))
    else $error("clock word not loaded on request");

  chk_rd_idle: assert property (
    !bus_i.rd |=> rd_data_o == 16'h0000)
    else $error("read data outside read slot");

endmodule

`default_nettype wire

/* hw/csb_pkg.sv */
package csb_pkg;

  // Register word indexes; the read/write port is word addressed
  localparam logic [4:0] IDX_FUSE      = 5'h00;
  localparam logic [4:0] IDX_DROP_CNT  = 5'h01;
  localparam logic [4:0] IDX_ERR_NUM   = 5'h02;
  localparam logic [4:0] IDX_ERR_YM    = 5'h03;
  localparam logic [4:0] IDX_ERR_DH    = 5'h04;
  localparam logic [4:0] IDX_ERR_MS    = 5'h05;
  localparam logic [4:0] IDX_ERR_CLASS = 5'h06;
  localparam logic [4:0] IDX_ERR_INFO  = 5'h07;
  localparam logic [4:0] IDX_RUN_STATE = 5'h08;
  localparam logic [4:0] IDX_CYC_TIME  = 5'h09;
  localparam logic [4:0] IDX_CYC_MAX   = 5'h0a;
  localparam logic [4:0] IDX_CLK_YM    = 5'h0b;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Every register resets to zero
  localparam logic [15:0] RST_VAL = 16'h0000;

  // Error detail classification codes
  localparam logic [15:0] CLASS_UNIT  = 16'h0001;
  localparam logic [15:0] CLASS_PARAM = 16'h0002;

  // Run state word fields
  localparam int STATE_LSB = 0;
  localparam int CAUSE_LSB = 4;
  localparam logic [3:0] STATE_RUN    = 4'h0;
  localparam logic [3:0] STATE_STOP   = 4'h2;
  localparam logic [3:0] CAUSE_SWITCH = 4'h0;
  localparam logic [3:0] CAUSE_ERROR  = 4'h4;

  // Millisecond timebase
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] CYC_SAT = 16'hffff;

  localparam int N_MOD = 64;

  // BCD time of day, two digits per field
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } csb_time_t;

  // Self-diagnosis report
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
    logic        is_param;
    logic        is_cpu;
    logic [1:0]  cpu_idx;
    logic [15:0] number;
    logic        stop;
  } csb_err_t;

  // Register port request
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } csb_bus_req_t;

endpackage

/* sim/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic                  mclk_i;
  logic                  rstn_i;
  csb_pkg::csb_bus_req_t bus_i;
  logic [15:0]           rd_data_o;
  logic [63:0]           fuse_blown_i;
  logic                  supply_drop_i;
  csb_pkg::csb_err_t     err_i;
  csb_pkg::csb_time_t    rtc_i;
  logic                  run_switch_i;
  logic                  main_pass_i;
  logic                  clk_req_i;
  logic                  running_o;
  int                    n_mismatch;
  int                    checks;

  // Short millisecond so cycle times fit in a brief run
  csb_status_bank #(.N_MOD(64), .MS_CYCLES(10)) i_dut (
    .mclk_i        (mclk_i),
    .rstn_i        (rstn_i),
    .bus_i         (bus_i),
    .rd_data_o     (rd_data_o),
    .fuse_blown_i  (fuse_blown_i),
    .supply_drop_i (supply_drop_i),
    .err_i         (err_i),
    .rtc_i         (rtc_i),
    .run_switch_i  (run_switch_i),
    .main_pass_i   (main_pass_i),
    .clk_req_i     (clk_req_i),
    .running_o     (running_o)
  );

  initial mclk_i = 1'b0;
  always #4 mclk_i = ~mclk_i;

  ////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Bus tasks start and end on a rising edge, so strobes never meet in one step
  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    @(negedge mclk_i);
    chk(rd_data_o, exp);
    @(posedge mclk_i);
  endtask

  task automatic pass_pulse;
    @(posedge mclk_i);
    main_pass_i <= 1'b1;
    @(posedge mclk_i);
    main_pass_i <= 1'b0;
  endtask

  task automatic drop_pulse;
    @(posedge mclk_i);
    supply_drop_i <= 1'b1;
    @(posedge mclk_i);
    supply_drop_i <= 1'b0;
  endtask

  task automatic err_pulse(input logic [15:0] c, input logic p, input logic u,
                           input logic [1:0] ix, input logic [15:0] n, input logic s);
    @(posedge mclk_i);
    err_i <= '{valid: 1'b1, code: c, is_param: p, is_cpu: u, cpu_idx: ix,
               number: n, stop: s};
    @(posedge mclk_i);
    err_i.valid <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rstn_i = 1'b0;
    bus_i = '0;
    fuse_blown_i = '0;
    supply_drop_i = 1'b0;
    err_i = '0;
    rtc_i = '{8'h95, 8'h10, 8'h25, 8'h10, 8'h35, 8'h48};
    run_switch_i = 1'b1;
    main_pass_i = 1'b0;
    clk_req_i = 1'b0;
    n_mismatch = 0;
    checks = 0;
    repeat (10) @(posedge mclk_i);
    rstn_i <= 1'b1;

    for (int i = 0; i < 12; i++) rd_chk(5'(i), 16'h0000);
    rd_chk(5'h1f, 16'h0000);
    $display("test reset values done");

    fuse_blown_i <= 64'h0000_0000_0000_0220;
    @(posedge mclk_i);
    rd_chk(csb_pkg::IDX_FUSE, 16'h0005);
    $display("test fuse done");

    drop_pulse();
    drop_pulse();
    rd_chk(csb_pkg::IDX_DROP_CNT, 16'h0002);
    run_switch_i <= 1'b0;
    drop_pulse();
    rd_chk(csb_pkg::IDX_DROP_CNT, 16'h0002);
    run_switch_i <= 1'b1;
    $display("test supply drop done");

    // Long enough to top the interval measured since reset
    pass_pulse();
    repeat (54) @(posedge mclk_i);
    pass_pulse();
    rd_chk(csb_pkg::IDX_CYC_TIME, 16'h0005);
    rd_chk(csb_pkg::IDX_CYC_MAX, 16'h0005);
    rd_chk(csb_pkg::IDX_RUN_STATE, 16'h0000);
    pass_pulse();
    repeat (14) @(posedge mclk_i);
    pass_pulse();
    rd_chk(csb_pkg::IDX_CYC_TIME, 16'h0001);
    rd_chk(csb_pkg::IDX_CYC_MAX, 16'h0005);
    $display("test cycle time done");

    err_pulse(16'h1234, 1'b0, 1'b1, 2'd2, 16'h0000, 1'b0);
    rd_chk(csb_pkg::IDX_ERR_NUM, 16'h1234);
    rd_chk(csb_pkg::IDX_ERR_YM, 16'h9510);
    rd_chk(csb_pkg::IDX_ERR_DH, 16'h2510);
    rd_chk(csb_pkg::IDX_ERR_MS, 16'h3548);
    rd_chk(csb_pkg::IDX_ERR_CLASS, csb_pkg::CLASS_UNIT);
    rd_chk(csb_pkg::IDX_ERR_INFO, 16'h0003);
    rtc_i <= '{8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59};
    repeat (3) @(posedge mclk_i);
    rd_chk(csb_pkg::IDX_ERR_YM, 16'h9510);
    rd_chk(csb_pkg::IDX_ERR_MS, 16'h3548);
    err_pulse(16'h0b01, 1'b1, 1'b0, 2'd0, 16'h0007, 1'b1);
    rd_chk(csb_pkg::IDX_ERR_NUM, 16'h0b01);
    rd_chk(csb_pkg::IDX_ERR_DH, 16'h3123);
    rd_chk(csb_pkg::IDX_ERR_CLASS, csb_pkg::CLASS_PARAM);
    rd_chk(csb_pkg::IDX_ERR_INFO, 16'h0007);
    chk({15'h0000, running_o}, 16'h0000);
    $display("test error report done");

    pass_pulse();
    rd_chk(csb_pkg::IDX_RUN_STATE, 16'h0042);
    // A later switch stop must not replace the earlier error cause
    run_switch_i <= 1'b0;
    pass_pulse();
    rd_chk(csb_pkg::IDX_RUN_STATE, 16'h0042);
    $display("test stop cause done");

    bus_wr(csb_pkg::IDX_CLK_YM, 16'h9307);
    rd_chk(csb_pkg::IDX_CLK_YM, 16'h9307);
    bus_wr(csb_pkg::IDX_FUSE, 16'h1234);
    rd_chk(csb_pkg::IDX_FUSE, 16'h0005);
    @(posedge mclk_i);
    clk_req_i <= 1'b1;
    @(posedge mclk_i);
    clk_req_i <= 1'b0;
    rd_chk(csb_pkg::IDX_CLK_YM, 16'h9912);
    $display("test clock word done");

    // Module zero among others must win
    fuse_blown_i <= 64'h0000_0000_8000_0001;
    @(posedge mclk_i);
    rd_chk(csb_pkg::IDX_FUSE, 16'h0000);
    $display("test fuse zero done");

    // Switch still at stop: reset must clear the latched error cause
    do_reset();
    rd_chk(csb_pkg::IDX_CYC_MAX, 16'h0000);
    rd_chk(csb_pkg::IDX_DROP_CNT, 16'h0000);
    pass_pulse();
    rd_chk(csb_pkg::IDX_RUN_STATE, 16'h0002);
    run_switch_i <= 1'b1;
    pass_pulse();
    rd_chk(csb_pkg::IDX_RUN_STATE, 16'h0000);
    chk({15'h0000, running_o}, 16'h0001);
    $display("test second reset done");
    wrap_up();
  end
endmodule

`default_nettype wire
